//--- design/power_wake_reset_control.sv
// Power-mode sequencer, start logic, reset merge and register slave
`timescale 1ns/10ps
// What this block does
// - After any reset the main clock selects the internal RC oscillator.
// - Sleep halts the processor until reset or interrupt.
// - Deep-sleep adds analog off; watchdog osc and brownout may stay on.
// - Twelve port pins plus alarm match wake the chip from Deep-sleep.
// - Deep power-down powers only alarm counter, four registers, wake pin.
// - Only the wake pin, alarm match or a reset source leaves Deep power-down.
// - Each start-logic source has its own interrupt line.
// - Wake detection needs no running clock.
// - Chip reset comes from reset pin, watchdog, power-on or brownout.
// - Any reset starts the internal RC oscillator and flash init.
// - Reset release starts fetch at address zero with registers reset.
// - 32-bit alarm counter gives a maskable interrupt on compare match.
// - Alarm tick: 1 Hz, delayed 1 Hz, 1 kHz or divided main clock.
module power_wake_reset_control
  import pwr_pkg::*;
(
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins and analog sources
  input wire logic [11:0] wakePins,
  input wire logic resetPin_b,
  input wire logic wakePin_b,
  input wire logic brownoutDetect,
  input wire logic [2:0] alarmTicks,
  input wire logic analogReady,
  // Processor and interrupt controller
  input wire logic modeReq,
  input wire logic [1:0] modeSel,
  input wire logic cpuBusIdle,
  input wire logic irqPending,
  input wire logic wdtReset,
  output logic cpuRun,
  output logic [31:0] bootAddr,
  output logic [12:0] wakeIrq,
  // Power and clock controls
  output logic clockWakeReq,
  output logic mainClkSel,
  output logic internalRcOscillatorOn,
  output logic flashInit,
  output logic analogOn,
  output logic wdtOscOn,
  output logic brownoutOn,
  output logic coreOn,
  output logic chipReset
);
  pwrState_t state_q;
  pwrState_t state_d;
  pwrMode_t mode_q;
  ahbAddr_t aph_q;
  logic [2:0] ctrl_q;
  logic [12:0] wakeEn_q;
  logic [12:0] pend_q;
  alarmCfg_t alarmCfg_q;
  logic [31:0] alarmMatch_q;
  logic [3:0] cause_q;
  logic [31:0] gpreg_q [NUM_GPREG];
  logic [31:0] hrdata_q;
  logic [11:0] pinPrev_q;
  logic wakePinPrev_q;
  logic [9:0] cnt_q;
  logic [SYN_W-1:0] syn;
  logic [31:0] alarmCount;
  logic alarmHit;
  logic [31:0] readVal;

  // Filtered pins
  wake_sync #(.W(SYN_W), .RST_VAL(SYN_RST)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .rawIn({alarmTicks, brownoutDetect, wakePin_b, resetPin_b, wakePins}),
    .syncOut(syn)
  );

  // Reset merge
  wire pinRst = !syn[SYN_RESET_PIN];
  wire brownoutRst = syn[SYN_BROWNOUT];
  wire dpdExit = (state_q == ST_DPD) &&
    ((wakePinPrev_q && !syn[SYN_WAKE_PIN]) || alarmHit);
  wire resetSrc = pinRst | wdtReset | brownoutRst | dpdExit;

  // Bus decode
  wire addrPhase = hsel & htrans[1] & hready;
  wire wrEn = aph_q.valid & aph_q.write;
  wire [7:0] wa = aph_q.addr;
  wire wrCtrl = wrEn && (wa == OFS_CTRL);
  wire wrWakeEn = wrEn && (wa == OFS_WAKE_EN);
  wire wrPend = wrEn && (wa == OFS_WAKE_PEND);
  wire wrAlarmCtrl = wrEn && (wa == OFS_ALARM_CTRL);
  wire wrAlarmCount = wrEn && (wa == OFS_ALARM_COUNT);
  wire wrAlarmMatch = wrEn && (wa == OFS_ALARM_MATCH);
  wire wrCause = wrEn && (wa == OFS_RESET_CAUSE);
  wire [7:0] gpIdx = wa - OFS_GPREG0;
  wire wrGp = wrEn && (wa >= OFS_GPREG0) && (gpIdx < 8'(NUM_GPREG * 4));

  // Start logic
  wire [11:0] pinRise = syn[11:0] & ~pinPrev_q;
  wire [12:0] pendSet = {alarmHit, pinRise} & wakeEn_q;
  wire [12:0] pendClr = wrPend ? hwdata[12:0] : 13'h0;
  wire [12:0] pend_d = (pend_q & ~pendClr) | pendSet;
  wire irqGate = (state_q == ST_RUN) || (state_q == ST_SLEEP);
  wire anyPend = |(pend_q & wakeEn_q);
  wire [3:0] causeSet = {brownoutRst, 1'b0, wdtReset, pinRst};
  wire [3:0] causeClr = wrCause ? hwdata[3:0] : 4'h0;
  wire cntDone = (cnt_q == 10'(RESET_HOLD_CYC - 1));
  wire stableDone = (cnt_q >= 10'(STABLE_CYC - 1));

  alarm_counter u_alarm (
    .mclk(mclk),
    .rst_b(rst_b),
    .cfg(alarmCfg_q),
    .ticks(syn[SYN_W-1:SYN_TICK]),
    .loadEn(wrAlarmCount),
    .loadVal(hwdata),
    .matchVal(alarmMatch_q),
    .count(alarmCount),
    .matchPulse(alarmHit)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET: begin
        if (cntDone) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (modeReq) begin
          state_d = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (cpuBusIdle) begin
          state_d = (mode_q == MODE_DEEP_PD) ? ST_DPD :
            (mode_q == MODE_DEEP_SLEEP) ? ST_DSLEEP : ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (irqPending || anyPend) begin
          state_d = ST_RUN;
        end
      end
      ST_DSLEEP: begin
        if (anyPend || (|pendSet)) begin
          state_d = ST_RESTORE;
        end
      end
      ST_DPD: begin
        state_d = ST_DPD;
      end
      ST_RESTORE: begin
        if (analogReady && stableDone) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (resetSrc) begin
      state_d = ST_RESET;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_RESET;
      mode_q <= MODE_SLEEP;
      cnt_q <= 10'h0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_RUN && modeReq) begin
        mode_q <= (modeSel == 2'h2) ? MODE_DEEP_PD :
          (modeSel == 2'h1) ? MODE_DEEP_SLEEP : MODE_SLEEP;
      end
      // Hold at zero while a source still asserts reset
      cnt_q <= (state_d != state_q || resetSrc) ? 10'h0 : cnt_q + 10'h1;
    end
  end

  // Control registers; all but alarmCfg_q and the pin history flops returned to defaults by every reset source
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      wakeEn_q <= 13'h0;
      alarmCfg_q <= ALARM_CFG_RST;
      pend_q <= 13'h0;
      pinPrev_q <= 12'h0;
      wakePinPrev_q <= 1'b1;
    end else if (resetSrc) begin
      ctrl_q <= CTRL_RST;
      wakeEn_q <= 13'h0;
      pend_q <= 13'h0;
      pinPrev_q <= syn[11:0];
      wakePinPrev_q <= syn[SYN_WAKE_PIN];
    end else begin
      ctrl_q <= wrCtrl ? hwdata[2:0] : ctrl_q;
      wakeEn_q <= wrWakeEn ? hwdata[12:0] : wakeEn_q;
      alarmCfg_q <= wrAlarmCtrl ? hwdata[11:0] : alarmCfg_q;
      pend_q <= pend_d;
      pinPrev_q <= syn[11:0];
      wakePinPrev_q <= syn[SYN_WAKE_PIN];
    end
  end

  // Retained domain: cleared only by power-on
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alarmMatch_q <= 32'h0;
      cause_q <= CAUSE_RST;
      for (int i = 0; i < NUM_GPREG; i++) begin
        gpreg_q[i] <= 32'h0;
      end
    end else begin
      alarmMatch_q <= wrAlarmMatch ? hwdata : alarmMatch_q;
      cause_q <= (cause_q & ~causeClr) | causeSet;
      if (wrGp) begin
        gpreg_q[gpIdx[3:2]] <= hwdata;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    readVal = 32'h0;
    unique case (haddr[7:0])
      OFS_CTRL: readVal = {29'h0, ctrl_q};
      OFS_WAKE_EN: readVal = {19'h0, wakeEn_q};
      OFS_WAKE_PEND: readVal = {19'h0, pend_q};
      OFS_ALARM_CTRL: readVal = {20'h0, alarmCfg_q};
      OFS_ALARM_COUNT: readVal = alarmCount;
      OFS_ALARM_MATCH: readVal = alarmMatch_q;
      OFS_RESET_CAUSE: readVal = {28'h0, cause_q};
      OFS_STATUS: readVal = {28'h0, analogReady, state_q};
      OFS_GPREG0: readVal = gpreg_q[0];
      OFS_GPREG0 + 8'h4: readVal = gpreg_q[1];
      OFS_GPREG0 + 8'h8: readVal = gpreg_q[2];
      OFS_GPREG0 + 8'hc: readVal = gpreg_q[3];
      default: readVal = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aph_q <= '0;
      hrdata_q <= 32'h0;
    end else begin
      aph_q <= '{valid: addrPhase, write: hwrite, addr: haddr[7:0]};
      if (addrPhase && !hwrite) begin
        hrdata_q <= readVal;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Power and clock outputs
  wire deepOff = (state_q == ST_DSLEEP) || (state_q == ST_DPD);
  assign cpuRun = (state_q == ST_RUN);
  assign bootAddr = 32'h0;
  assign mainClkSel = ctrl_q[CTRL_MAINCLK];
  assign internalRcOscillatorOn = !deepOff;
  assign flashInit = (state_q == ST_RESET);
  assign chipReset = (state_q == ST_RESET);
  assign analogOn = !deepOff;
  assign wdtOscOn = analogOn ||
    (state_q == ST_DSLEEP && ctrl_q[CTRL_KEEP_WDT]);
  assign brownoutOn = analogOn ||
    (state_q == ST_DSLEEP && ctrl_q[CTRL_KEEP_BROWNOUT]);
  assign coreOn = (state_q != ST_DPD);
  // Interrupt lines held back in every state except ST_RUN and ST_SLEEP
  assign wakeIrq = pend_q & wakeEn_q & {alarmCfg_q.irqEn, 12'hfff}
    & {13{irqGate}};
  // Raw pin levels reach the oscillator wake request with no clock involved
  assign clockWakeReq = (state_q == ST_DPD) ? !wakePin_b :
    |(wakePins & wakeEn_q[11:0]);

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // The long hold is counted by cnt_q; the sequence only needs a quiet lead-in
  sequence resetHold;
    (state_q == ST_RESET && !resetSrc) [*8];
  endsequence
  sequence releasePoint;
    state_q == ST_RESET && cntDone && !resetSrc;
  endsequence

  AST_RESET_CLK: assert property (
    resetSrc |=> !mainClkSel && flashInit)
    else $error("clock select or flash init wrong after reset");
  AST_SLEEP_HALT: assert property (
    (state_q == ST_SLEEP) |-> !cpuRun && analogOn)
    else $error("sleep does not halt processor");
  AST_DSLEEP_OFF: assert property (
    (state_q == ST_DSLEEP) |->
    !analogOn && wdtOscOn == ctrl_q[CTRL_KEEP_WDT])
    else $error("deep-sleep power");
  AST_PIN_WAKE: assert property (
    (state_q == ST_DSLEEP && |pendSet && !resetSrc) |=>
    state_q == ST_RESTORE)
    else $error("pin wake lost");
  AST_DPD_CORE: assert property (
    (state_q == ST_DPD) |-> !coreOn && !internalRcOscillatorOn)
    else $error("core powered in deep power-down");
  AST_DPD_EXIT: assert property (
    (state_q == ST_DPD && !dpdExit && !resetSrc) |=> state_q == ST_DPD)
    else $error("bad power-down exit");
  AST_IRQ_LINE: assert property (
    (state_q == ST_RUN) |->
    wakeIrq[11:0] == (pend_q[11:0] & wakeEn_q[11:0]))
    else $error("pin interrupt line wrong");
  AST_ASYNC_WAKE: assert property (
    (state_q != ST_DPD && |(wakePins & wakeEn_q[11:0])) |-> clockWakeReq)
    else $error("no wake req");
  AST_RESET_MERGE: assert property (
    wdtReset |=> state_q == ST_RESET && cause_q[CAUSE_WDT])
    else $error("reset not merged");
  AST_RESET_RELEASE: assert property (
    resetHold ##1 releasePoint |=> cpuRun && bootAddr == 32'h0)
    else $error("late processor release");
  AST_ALARM_IRQ: assert property (
    (alarmHit && wakeEn_q[ALARM_BIT] && !resetSrc && !wrPend) |=>
    pend_q[ALARM_BIT])
    else $error("match lost");
  AST_RESTORE_HOLD: assert property (
    (state_q == ST_RESTORE) |-> !cpuRun && wakeIrq == 13'h0)
    else $error("released before restore");
  AST_ENTER_WAIT: assert property (
    (state_q == ST_ENTER && !cpuBusIdle && !resetSrc) |=>
    state_q == ST_ENTER)
    else $error("entered while busy");
endmodule

//--- common/pwr_pkg.sv
// Shared constants and types for the power, wake and reset controller
package pwr_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_HOLD_NS = 2000;
  localparam int RESET_HOLD_CYC =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STABLE_NS = 20000;
  localparam int STABLE_CYC = (STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAKE_EN = 8'h04;
  localparam logic [7:0] OFS_WAKE_PEND = 8'h08;
  localparam logic [7:0] OFS_ALARM_CTRL = 8'h0c;
  localparam logic [7:0] OFS_ALARM_COUNT = 8'h10;
  localparam logic [7:0] OFS_ALARM_MATCH = 8'h14;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_GPREG0 = 8'h20;
  localparam int NUM_GPREG = 4;

  // Field positions
  localparam int CTRL_MAINCLK = 0;
  localparam int CTRL_KEEP_WDT = 1;
  localparam int CTRL_KEEP_BROWNOUT = 2;
  localparam int NUM_WAKE_PINS = 12;
  localparam int ALARM_BIT = 12;
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_WDT = 1;
  localparam int CAUSE_POR = 2;
  localparam int CAUSE_BROWNOUT = 3;

  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] CAUSE_RST = 4'h4;

  // Synchroniser lanes: 0..11 wake pins, then the rest
  localparam int SYN_W = 18;
  localparam int SYN_RESET_PIN = 12;
  localparam int SYN_WAKE_PIN = 13;
  localparam int SYN_BROWNOUT = 14;
  localparam int SYN_TICK = 15;
  localparam logic [17:0] SYN_RST = 18'h03000;

  // Alarm clock selection
  localparam logic [1:0] ASEL_1HZ = 2'h0;
  localparam logic [1:0] ASEL_1HZ_DLY = 2'h1;
  localparam logic [1:0] ASEL_1KHZ = 2'h2;
  localparam logic [1:0] ASEL_MAIN = 2'h3;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_DEEP_SLEEP, MODE_DEEP_PD}
    pwrMode_t;
  typedef enum logic [2:0] {ST_RESET, ST_RUN, ST_ENTER, ST_SLEEP,
    ST_DSLEEP, ST_DPD, ST_RESTORE} pwrState_t;

  typedef struct packed {
    logic [7:0] div;
    logic irqEn;
    logic [1:0] sel;
    logic enable;
  } alarmCfg_t;
  localparam alarmCfg_t ALARM_CFG_RST = '0;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahbAddr_t;
endpackage

//--- design/wake_sync.sv
// Three-stage synchroniser whose output moves when stages two and three agree
`timescale 1ns/10ps
module wake_sync
  import pwr_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Raw and filtered levels
  input wire logic [W-1:0] rawIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      out_q <= RST_VAL;
    end else begin
      s1_q <= rawIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
    end
  end

  assign syncOut = out_q;
endmodule

//--- design/alarm_counter.sv
// Always-on 32-bit alarm counter with selectable tick and compare match
`timescale 1ns/10ps
module alarm_counter
  import pwr_pkg::*;
(
  // Clock and retained-domain reset
  input wire logic mclk,
  input wire logic rst_b,
  // Configuration
  input wire alarmCfg_t cfg,
  input wire logic [2:0] ticks,
  input wire logic loadEn,
  input wire logic [31:0] loadVal,
  input wire logic [31:0] matchVal,
  // State
  output logic [31:0] count,
  output logic matchPulse
);
  logic [2:0] tickPrev_q;
  logic [7:0] div_q;
  logic [31:0] count_q;
  logic match_q;
  wire [2:0] tickRise = ticks & ~tickPrev_q;
  wire divWrap = (div_q >= cfg.div);
  wire step = cfg.enable & ((cfg.sel == ASEL_1HZ) ? tickRise[0] :
    (cfg.sel == ASEL_1HZ_DLY) ? tickRise[1] :
    (cfg.sel == ASEL_1KHZ) ? tickRise[2] : divWrap);
  wire [31:0] countNext = count_q + 32'h1;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tickPrev_q <= 3'h0;
      div_q <= 8'h0;
      count_q <= 32'h0;
      match_q <= 1'b0;
    end else begin
      tickPrev_q <= ticks;
      div_q <= divWrap ? 8'h0 : div_q + 8'h1;
      // A load from software beats a tick in the same cycle
      count_q <= loadEn ? loadVal : (step ? countNext : count_q);
      match_q <= !loadEn && step && (countNext == matchVal);
    end
  end

  assign count = count_q;
  assign matchPulse = match_q;
endmodule

//--- testbench/cpu_model.sv
// Processor and interrupt controller stand-in facing the power sequencer
`timescale 1ns/10ps
module cpu_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Bench control
  input wire logic goReq,
  input wire logic [1:0] goMode,
  input wire logic [3:0] drain,
  input wire logic extIrq,
  // Sequencer side
  input wire logic cpuRun,
  input wire logic [12:0] wakeIrq,
  output logic modeReq,
  output logic [1:0] modeSel,
  output logic cpuBusIdle,
  output logic irqPending
);
  logic [3:0] busyCnt_q;
  // Outstanding bus traffic drains after the request, so entry must wait
  assign cpuBusIdle = !cpuRun && busyCnt_q == 4'h0;
  // Controller raises its pending line from any enabled interrupt line
  assign irqPending = |wakeIrq || extIrq;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      modeReq <= 1'b0;
      modeSel <= 2'h0;
      busyCnt_q <= 4'h0;
    end else begin
      modeReq <= goReq && cpuRun;
      if (goReq && cpuRun) begin
        modeSel <= goMode;
        busyCnt_q <= drain;
      end else if (busyCnt_q != 4'h0) begin
        busyCnt_q <= busyCnt_q - 4'h1;
      end
    end
  end
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the power, wake and reset controller
`timescale 1ns/10ps
module tb_top
  import pwr_pkg::*;
;
  localparam int LIMIT = 20000;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [11:0] wakePins = 12'h0;
  logic resetPin_b = 1'b1;
  logic wakePin_b = 1'b1;
  logic brownoutDetect = 1'b0;
  logic [2:0] alarmTicks = 3'h0;
  logic analogReady = 1'b1;
  logic wdtReset = 1'b0;
  logic goReq = 1'b0;
  logic [1:0] goMode = 2'h0;
  logic [3:0] drain = 4'h0;
  logic extIrq = 1'b0;
  logic hreadyout, hresp, modeReq, cpuBusIdle, irqPending, cpuRun;
  logic clockWakeReq, mainClkSel, internalRcOscillatorOn;
  logic flashInit, analogOn;
  logic wdtOscOn, brownoutOn, coreOn, chipReset;
  logic [31:0] hrdata, bootAddr, rd;
  logic [1:0] modeSel;
  logic [12:0] wakeIrq;
  int miscompares = 0;
  int checkCount = 0;
  int cyc = 0;
  int n;

  power_wake_reset_control DUT (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .wakePins(wakePins),
    .resetPin_b(resetPin_b), .wakePin_b(wakePin_b),
    .brownoutDetect(brownoutDetect), .alarmTicks(alarmTicks),
    .analogReady(analogReady), .modeReq(modeReq), .modeSel(modeSel),
    .cpuBusIdle(cpuBusIdle), .irqPending(irqPending), .wdtReset(wdtReset),
    .cpuRun(cpuRun), .bootAddr(bootAddr), .wakeIrq(wakeIrq),
    .clockWakeReq(clockWakeReq), .mainClkSel(mainClkSel),
    .internalRcOscillatorOn(internalRcOscillatorOn),
    .flashInit(flashInit), .analogOn(analogOn), .wdtOscOn(wdtOscOn),
    .brownoutOn(brownoutOn), .coreOn(coreOn), .chipReset(chipReset));

  cpu_model cpu (.mclk(mclk), .rst_b(rst_b), .goReq(goReq),
    .goMode(goMode), .drain(drain), .extIrq(extIrq), .cpuRun(cpuRun),
    .wakeIrq(wakeIrq), .modeReq(modeReq), .modeSel(modeSel),
    .cpuBusIdle(cpuBusIdle), .irqPending(irqPending));

  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd, e, m);
    chk(32'({hreadyout, hresp}), 32'h2, "okay response");
  endtask

  // Sample one step after the edge so flop updates have landed
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic req(input logic [1:0] m, input logic [3:0] d);
    @(posedge mclk);
    goReq <= 1'b1;
    goMode <= m;
    drain <= d;
    @(posedge mclk);
    goReq <= 1'b0;
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    tick(20);
    chk(32'({flashInit, chipReset, internalRcOscillatorOn, cpuRun,
        mainClkSel}), 32'h1c, "in reset");
    @(posedge mclk);
    rst_b <= 1'b1;
    tick(RESET_HOLD_CYC - 5);
    chk(32'(cpuRun), 32'h0, "held in reset");
    n = 0;
    while (cpuRun !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk(32'(cpuRun), 32'h1, "released");
    chk(bootAddr, 32'h0, "boot address");
    rchk(OFS_CTRL, 32'(CTRL_RST), "ctrl reset");
    rchk(OFS_RESET_CAUSE, 32'(CAUSE_RST), "por cause");
    rchk(OFS_STATUS, 32'h9, "status run");
    rchk(8'h3c, 32'h0, "unmapped");
    $display("reset test done");

    wr(OFS_WAKE_EN, 32'h801);
    @(posedge mclk);
    wakePins <= 12'h020;
    tick(1);
    chk(32'(clockWakeReq), 32'h0, "disabled pin");
    tick(6);
    chk(32'(wakeIrq), 32'h0, "disabled irq");
    @(posedge mclk);
    wakePins <= 12'h820;
    tick(1);
    chk(32'(clockWakeReq), 32'h1, "clockless wake");
    tick(6);
    chk(32'(wakeIrq), 32'h800, "own irq line");
    wr(OFS_WAKE_PEND, 32'h800);
    @(posedge mclk);
    wakePins <= 12'h0;
    tick(2);
    chk(32'(wakeIrq), 32'h0, "pending cleared");
    $display("start logic test done");

    req(2'h0, 4'h0);
    tick(6);
    chk(32'({cpuRun, analogOn}), 32'h1, "sleep");
    @(posedge mclk);
    extIrq <= 1'b1;
    tick(4);
    chk(32'(cpuRun), 32'h1, "irq wakes sleep");
    @(posedge mclk);
    extIrq <= 1'b0;
    $display("sleep test done");

    wr(OFS_CTRL, 32'h2);
    req(2'h1, 4'h8);
    tick(4);
    chk(32'({cpuRun, analogOn}), 32'h1, "waits for idle bus");
    while (analogOn !== 1'b0) tick(1);
    chk(32'({internalRcOscillatorOn, wdtOscOn, brownoutOn}), 32'h2,
        "deep-sleep power");
    @(posedge mclk);
    analogReady <= 1'b0;
    wakePins <= 12'h800;
    while (analogOn !== 1'b1) tick(1);
    chk(32'(cpuRun), 32'h0, "analog before core");
    @(posedge mclk);
    analogReady <= 1'b1;
    n = 1;
    while (cpuRun !== 1'b1) begin
      tick(1);
      n++;
    end
    chk(32'(n > STABLE_CYC - 4 && n < STABLE_CYC + 4), 32'h1,
        "settle time");
    chk(32'(wakeIrq), 32'h800, "wake irq delivered");
    @(posedge mclk);
    wakePins <= 12'h0;
    wr(OFS_WAKE_PEND, 32'h800);
    $display("deep-sleep test done");

    wr(OFS_WAKE_EN, 32'h1000);
    wr(OFS_ALARM_MATCH, 32'h10);
    wr(OFS_ALARM_COUNT, 32'h0);
    wr(OFS_ALARM_CTRL, 32'h7);
    tick(30);
    chk(32'(wakeIrq), 32'h0, "alarm masked");
    rchk(OFS_WAKE_PEND, 32'h1000, "alarm pending");
    wr(OFS_ALARM_CTRL, 32'hf);
    tick(2);
    chk(32'(wakeIrq), 32'h1000, "alarm irq");
    wr(OFS_WAKE_PEND, 32'h1000);
    for (int s = 0; s < 3; s++) begin
      wr(OFS_ALARM_CTRL, 32'(1 + 2 * s));
      wr(OFS_ALARM_COUNT, 32'h0);
      repeat (3) begin
        @(posedge mclk);
        alarmTicks <= 3'(1 << s);
        repeat (4) @(posedge mclk);
        alarmTicks <= 3'h0;
        repeat (4) @(posedge mclk);
      end
      tick(6);
      rchk(OFS_ALARM_COUNT, 32'h3, "tick source count");
    end
    wr(OFS_ALARM_CTRL, 32'h0);
    $display("alarm test done");

    wr(OFS_GPREG0 + 8'h4, 32'h5a5a0f0f);
    wr(OFS_WAKE_EN, 32'hfff);
    req(2'h2, 4'h0);
    while (coreOn !== 1'b0) tick(1);
    @(posedge mclk);
    wakePins <= 12'hfff;
    tick(10);
    chk(32'({coreOn, chipReset}), 32'h0, "pins ignored");
    @(posedge mclk);
    wakePins <= 12'h0;
    wakePin_b <= 1'b0;
    tick(6);
    chk(32'(chipReset), 32'h1, "wake pin exit");
    @(posedge mclk);
    wakePin_b <= 1'b1;
    while (cpuRun !== 1'b1) tick(1);
    rchk(OFS_GPREG0 + 8'h4, 32'h5a5a0f0f, "retained");
    rchk(OFS_ALARM_MATCH, 32'h10, "alarm kept");
    rchk(OFS_WAKE_EN, 32'h0, "wake enable reset");
    $display("power-down test done");

    for (int i = 0; i < 3; i++) begin
      wr(OFS_RESET_CAUSE, 32'hf);
      wr(OFS_CTRL, 32'h1);
      @(posedge mclk);
      resetPin_b <= (i != 0);
      wdtReset <= (i == 1);
      brownoutDetect <= (i == 2);
      tick(6);
      chk(32'({chipReset, flashInit, internalRcOscillatorOn, cpuRun}), 32'he,
          "reset source");
      @(posedge mclk);
      resetPin_b <= 1'b1;
      wdtReset <= 1'b0;
      brownoutDetect <= 1'b0;
      while (cpuRun !== 1'b1) tick(1);
      chk(32'(mainClkSel), 32'h0, "clock back on rc");
      rchk(OFS_RESET_CAUSE, 32'(i == 2 ? 8 : 1 << i), "cause");
    end
    $display("reset source test done");
    complete_run();
  end
endmodule
